// File: logic/pbit_access.sv
// Avalon-MM register front end for the personality bit array
//
// Contract
// - Select bits 2..0 pick row, bits 5..3 pick column.
// - Select bits 7..6 are plain storage, cleared by reset.
// - Reset clears the whole select register, row zero column zero.
// - Sensed bit shows the selected cell; reset leaves it alone.
// - Sensed bit has no effect on programming.
// - Program bit set drives the selected cell to one.
// - Reset clears the program bit.
// - Row-zero flag set exactly when row zero is selected.
// - Row-zero flag reads set right after reset.
// - Incrementing select steps rows; eighth step reaches next column row zero.
// - Erased cell reads zero.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module pbit_access
(
   // Clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst,
   // Avalon-MM slave
   input  wire logic [pbit_pkg::ADDR_W-1:0] i_address,
   input  wire logic                        i_read,
   input  wire logic                        i_write,
   input  wire logic [pbit_pkg::DATA_W-1:0] i_writedata,
   input  wire logic [3:0]                  i_byteenable,
   output logic [pbit_pkg::DATA_W-1:0]      o_readdata,
   output logic                             o_waitrequest,
   // Array side status
   output logic                             o_program_active,
   output logic [pbit_pkg::INDEX_W-1:0]     o_cell_index
);
   import pbit_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] cell_select;
   logic       program_control;
   logic       sensed_bit;
   logic       row_zero_flag;
   logic       done;
   logic       hit_select;
   logic       hit_status;
   logic       wr_go;
   logic       rd_go;

   assign hit_select = (i_address == CELL_SELECT_OFS);
   assign hit_status = (i_address == CELL_STATUS_OFS);

   // One wait cycle per access; the answer edge is the second one
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         done <= 1'b0;
      end else begin
         done <= (i_read || i_write) && !done;
      end
   end
   assign o_waitrequest = (i_read || i_write) && !done;
   assign wr_go         = i_write && done;
   assign rd_go         = i_read && done;

   // ----------------------------------------------------------------
   // Select register
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cell_select <= SELECT_RST;
      end else if (wr_go && hit_select && i_byteenable[0]) begin
         cell_select <= i_writedata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Program control
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         program_control <= PROGRAM_RST;
      end else if (wr_go && hit_status && i_byteenable[0]) begin
         program_control <= i_writedata[PROGRAM_BIT];
      end
   end

   // Only the low six bits reach the array
   assign o_cell_index     = cell_select[COL_MSB:ROW_LSB];
   assign o_program_active = program_control;
   // Combinational so a read right after a select write sees it
   assign row_zero_flag    = (cell_select[ROW_MSB:ROW_LSB] == 3'h0);

   pbit_cell_array u_array (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_index   (o_cell_index),
      .i_program (program_control),
      .o_sensed  (sensed_bit)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_readdata <= 32'h00000000;
      end else if (i_read && !done) begin
         if (hit_select) begin
            o_readdata <= {24'h000000, cell_select};
         end else if (hit_status) begin
            o_readdata <= {29'h00000000, sensed_bit, program_control, row_zero_flag};
         end else begin
            o_readdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_reset_select: assert property (@(posedge i_mclk)
      i_rst |=> cell_select == 8'h00)
      else $error("select not cleared by reset");
   chk_reset_spare: assert property (@(posedge i_mclk)
      i_rst |=> cell_select[SPARE_HI_BIT:SPARE_LO_BIT] == 2'h0)
      else $error("spare bits not cleared by reset");
   chk_reset_program: assert property (@(posedge i_mclk)
      i_rst |=> !o_program_active)
      else $error("program bit survived reset");
   chk_reset_rowzero: assert property (@(posedge i_mclk)
      i_rst |=> row_zero_flag)
      else $error("row zero flag clear after reset");
   chk_rowzero_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
      row_zero_flag == (o_cell_index[2:0] == 3'h0))
      else $error("row zero flag wrong");
   chk_select_write: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_select && i_byteenable[0] |=> cell_select == $past(i_writedata[7:0]))
      else $error("select write lost");
   chk_index_map: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_cell_index == cell_select[5:0])
      else $error("cell index mapping wrong");
   chk_status_read: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_read && !done && hit_status |=> o_readdata[0] == $past(row_zero_flag)
      && o_readdata[2] == $past(sensed_bit))
      else $error("status read stale");
   chk_wait_bound: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_read || i_write) |-> ##[0:1] !o_waitrequest)
      else $error("waitrequest held too long");

   // ----------------------------------------------------------------
   // Handshake checks
   // ----------------------------------------------------------------
   property first_cycle_stalls;
      @(posedge i_mclk) disable iff (i_rst)
      (i_read || i_write) && !done |-> o_waitrequest;
   endproperty : first_cycle_stalls
   chk_wait_first: assert property (first_cycle_stalls)
      else $error("first bus cycle not stalled");

   property answer_follows;
      @(posedge i_mclk) disable iff (i_rst)
      (i_read || i_write) && !done |=> done;
   endproperty : answer_follows
   chk_answer_follows: assert property (answer_follows)
      else $error("no answer cycle after request");

   // A held request must not be answered twice in a row
   property answer_single;
      @(posedge i_mclk) disable iff (i_rst)
      done |=> !done;
   endproperty : answer_single
   chk_answer_single: assert property (answer_single)
      else $error("answer cycle repeated");

   // ----------------------------------------------------------------
   // Read data checks
   // ----------------------------------------------------------------
   // Read data is loaded on the stalled cycle and must then stand
   property readdata_stands;
      @(posedge i_mclk) disable iff (i_rst)
      !(i_read && !done) |=> $stable(o_readdata);
   endproperty : readdata_stands
   chk_readdata_stands: assert property (readdata_stands)
      else $error("read data moved between reads");

   property unmapped_reads_zero;
      @(posedge i_mclk) disable iff (i_rst)
      i_read && !done && !hit_select && !hit_status |=> o_readdata == 32'h00000000;
   endproperty : unmapped_reads_zero
   chk_unmapped_read: assert property (unmapped_reads_zero)
      else $error("unmapped read not zero");

   property select_reads_back;
      @(posedge i_mclk) disable iff (i_rst)
      i_read && !done && hit_select |=> o_readdata == {24'h000000, $past(cell_select)};
   endproperty : select_reads_back
   chk_select_readback: assert property (select_reads_back)
      else $error("select read back wrong");

   property status_image;
      @(posedge i_mclk) disable iff (i_rst)
      i_read && !done && hit_status |=> o_readdata[31:3] == 29'h00000000
         && o_readdata[PROGRAM_BIT] == $past(program_control);
   endproperty : status_image
   chk_status_image: assert property (status_image)
      else $error("status image wrong");

   property status_row_flag;
      @(posedge i_mclk) disable iff (i_rst)
      i_read && !done && hit_status |=> o_readdata[ROW_ZERO_BIT]
         == ($past(cell_select[ROW_MSB:ROW_LSB]) == 3'h0);
   endproperty : status_row_flag
   chk_status_rowflag: assert property (status_row_flag)
      else $error("row zero flag read wrong");

   property write_keeps_readdata;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go |=> $stable(o_readdata);
   endproperty : write_keeps_readdata
   chk_write_readdata: assert property (write_keeps_readdata)
      else $error("write disturbed read data");

   // ----------------------------------------------------------------
   // Write checks
   // ----------------------------------------------------------------
   // Refused writes: lane 0 off or an unmapped address
   property lane_refused;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && !i_byteenable[0] |=> $stable(cell_select) && $stable(program_control);
   endproperty : lane_refused
   chk_lane_refused: assert property (lane_refused)
      else $error("write without lane 0 took effect");

   property unmapped_write_ignored;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && !hit_select && !hit_status |=> $stable(cell_select) && $stable(program_control);
   endproperty : unmapped_write_ignored
   chk_unmapped_write: assert property (unmapped_write_ignored)
      else $error("unmapped write took effect");

   property select_holds;
      @(posedge i_mclk) disable iff (i_rst)
      !(wr_go && hit_select && i_byteenable[0]) |=> $stable(cell_select);
   endproperty : select_holds
   chk_select_holds: assert property (select_holds)
      else $error("select changed without a write");

   property program_takes_write;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_status && i_byteenable[0]
         |=> program_control == $past(i_writedata[PROGRAM_BIT]);
   endproperty : program_takes_write
   chk_program_write: assert property (program_takes_write)
      else $error("program bit write lost");

   property program_holds;
      @(posedge i_mclk) disable iff (i_rst)
      !(wr_go && hit_status && i_byteenable[0]) |=> $stable(program_control);
   endproperty : program_holds
   chk_program_holds: assert property (program_holds)
      else $error("program bit changed without a write");

   property flag_from_write;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_select && i_byteenable[0]
         |=> row_zero_flag == ($past(i_writedata[ROW_MSB:ROW_LSB]) == 3'h0);
   endproperty : flag_from_write
   chk_flag_from_write: assert property (flag_from_write)
      else $error("row zero flag not from written row");

   property index_from_write;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_select && i_byteenable[0]
         |=> o_cell_index == $past(i_writedata[COL_MSB:ROW_LSB]);
   endproperty : index_from_write
   chk_index_from_write: assert property (index_from_write)
      else $error("cell index not from written value");

   property spare_from_write;
      @(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_select && i_byteenable[0] |=> cell_select[SPARE_HI_BIT:SPARE_LO_BIT]
         == $past(i_writedata[SPARE_HI_BIT:SPARE_LO_BIT]);
   endproperty : spare_from_write
   chk_spare_from_write: assert property (spare_from_write)
      else $error("spare bits not stored");

   property row_step_wraps;
      @(posedge i_mclk) disable iff (i_rst)
      cell_select[COL_MSB:ROW_LSB] == $past(cell_select[COL_MSB:ROW_LSB]) + 6'h01
         |-> row_zero_flag == ($past(cell_select[ROW_MSB:ROW_LSB]) == 3'h7);
   endproperty : row_step_wraps
   chk_row_step: assert property (row_step_wraps)
      else $error("increment did not wrap rows");

   // ----------------------------------------------------------------
   // Array checks
   // ----------------------------------------------------------------
   property program_reaches_cell;
      @(posedge i_mclk) disable iff (i_rst)
      program_control && $past(program_control) && $stable(o_cell_index) |-> sensed_bit;
   endproperty : program_reaches_cell
   chk_program_reaches: assert property (program_reaches_cell)
      else $error("held program bit did not set cell");

   property idle_keeps_cell;
      @(posedge i_mclk) disable iff (i_rst)
      !program_control ##1 $stable(o_cell_index) |-> $stable(sensed_bit);
   endproperty : idle_keeps_cell
   chk_idle_keeps_cell: assert property (idle_keeps_cell)
      else $error("cell changed with program bit clear");

   // Reset gates the switch, so a cut pulse leaves the cell as it was
   property reset_keeps_sense;
      @(posedge i_mclk)
      i_rst && o_cell_index == 6'h00 |=> $stable(sensed_bit);
   endproperty : reset_keeps_sense
   chk_reset_keeps_sense: assert property (reset_keeps_sense)
      else $error("reset disturbed sensed bit");

   // ----------------------------------------------------------------
   // Reset checks
   // ----------------------------------------------------------------
   property reset_clears_readdata;
      @(posedge i_mclk)
      i_rst |=> o_readdata == 32'h00000000;
   endproperty : reset_clears_readdata
   chk_reset_readdata: assert property (reset_clears_readdata)
      else $error("read data not cleared by reset");

   property reset_clears_answer;
      @(posedge i_mclk)
      i_rst |=> !done;
   endproperty : reset_clears_answer
   chk_reset_answer: assert property (reset_clears_answer)
      else $error("answer cycle survived reset");

   cov_program: cover property (@(posedge i_mclk) disable iff (i_rst)
      program_control ##1 !program_control);
   cov_rowzero_wrap: cover property (@(posedge i_mclk) disable iff (i_rst)
      !row_zero_flag ##1 row_zero_flag);
   cov_sense_one: cover property (@(posedge i_mclk) disable iff (i_rst)
      rd_go && hit_status && o_readdata[2]);
   cov_lane_refused: cover property (@(posedge i_mclk) disable iff (i_rst)
      wr_go && hit_select && !i_byteenable[0]);
   cov_unmapped_read: cover property (@(posedge i_mclk) disable iff (i_rst)
      rd_go && !hit_select && !hit_status);
endmodule : pbit_access

// File: logic/pbit_pkg.sv
// Package: register map, field layout and reset values for the personality bit array access
package pbit_pkg;
   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam int          CELLS           = 64;
   localparam int          INDEX_W         = 6;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0]  CELL_SELECT_OFS = 4'h0;
   localparam logic [3:0]  CELL_STATUS_OFS = 4'h4;
   // ----------------------------------------------------------------
   // Fields of the select register
   // ----------------------------------------------------------------
   localparam int          ROW_LSB         = 0;
   localparam int          ROW_MSB         = 2;
   localparam int          COL_LSB         = 3;
   localparam int          COL_MSB         = 5;
   localparam int          SPARE_LO_BIT    = 6;
   localparam int          SPARE_HI_BIT    = 7;
   // ----------------------------------------------------------------
   // Fields of the status and control register
   // ----------------------------------------------------------------
   localparam int          ROW_ZERO_BIT    = 0;
   localparam int          PROGRAM_BIT     = 1;
   localparam int          SENSED_BIT      = 2;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  SELECT_RST      = 8'h00;
   localparam logic        PROGRAM_RST     = 1'b0;
   localparam logic [63:0] ERASED_ARRAY    = 64'h0000000000000000;
endpackage : pbit_pkg

// File: logic/pbit_cell_array.sv
// Behavioural model of the 64-cell array with sense output and program switch
`timescale 1ns/1ps
module pbit_cell_array
(
   // Clock and reset
   input  wire logic                         i_mclk,
   input  wire logic                         i_rst,
   // Cell access
   input  wire logic [pbit_pkg::INDEX_W-1:0] i_index,
   input  wire logic                         i_program,
   output logic                              o_sensed
);
   import pbit_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Reset leaves cells alone: they are nonvolatile
   logic [CELLS-1:0] cells = ERASED_ARRAY;

   // Programming only ever sets a cell; the sensed value plays no part
   always_ff @(posedge i_mclk) begin
      if (i_program && !i_rst) begin
         cells[i_index] <= 1'b1;
      end
   end

   // Sense amplifier follows the selection, reset does not touch it
   assign o_sensed = cells[i_index];

   chk_program_sets_cell: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_program ##1 ($stable(i_index) && !i_rst) |-> o_sensed)
      else $error("programmed cell did not read one");
   chk_cell_monotone: assert property (@(posedge i_mclk)
      $stable(i_index) && $past(o_sensed) |-> o_sensed)
      else $error("cell went back to zero");
endmodule : pbit_cell_array

// File: test/personality_bit_array_access_tb_top.sv
// Self-checking bench for the personality bit array register front end
`timescale 1ns/1ps
module personality_bit_array_access_tb_top;
   import pbit_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus, model and bookkeeping
   // ----------------------------------------------------------------
   logic                i_mclk       = 1'b0;
   logic                i_rst        = 1'b1;
   logic [ADDR_W-1:0]   i_address    = '0;
   logic                i_read       = 1'b0;
   logic                i_write      = 1'b0;
   logic [DATA_W-1:0]   i_writedata  = '0;
   logic [3:0]          i_byteenable = 4'hF;
   logic [DATA_W-1:0]   o_readdata;
   logic                o_waitrequest;
   logic                o_program_active;
   logic [INDEX_W-1:0]  o_cell_index;
   int                  err_count    = 0;
   int                  checks_done  = 0;
   integer              seed         = 32'h4649;
   logic [63:0]         arr          = 64'h0000000000000000;
   logic [7:0]          sel          = 8'h00;
   logic [31:0]         q;
   always #12.5 i_mclk = ~i_mclk;
   pbit_access dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_program_active(o_program_active), .o_cell_index(o_cell_index));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task end_of_test;
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge i_mclk);
      i_address    <= a;
      i_write      <= wr;
      i_read       <= ~wr;
      i_writedata  <= d;
      i_byteenable <= be;
      for (n = 0; n < 20; n++) begin
         @(posedge i_mclk);
         if (o_waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         err_count++;
         end_of_test();
      end
      q = o_readdata;
      i_write <= 1'b0;
      i_read  <= 1'b0;
   endtask : bus
   task sel_wr(input logic [7:0] v);
      bus(1'b1, CELL_SELECT_OFS, {24'h0, v}, 4'hF);
      sel = v;
   endtask : sel_wr
   task look(input logic p);
      bus(1'b0, CELL_SELECT_OFS, 32'h0, 4'hF);
      chk(q, {24'h0, sel});
      chk({26'h0, o_cell_index}, 32'(sel[5:3]) * 8 + 32'(sel[2:0]));
      bus(1'b0, CELL_STATUS_OFS, 32'h0, 4'hF);
      chk(q, {29'h0, arr[sel[5:0]], p, sel[2:0] == 3'h0});
      chk({31'h0, o_program_active}, {31'h0, p});
   endtask : look
   // Select held while the switch is on
   task prog(input logic [7:0] v);
      sel_wr(v);
      bus(1'b1, CELL_STATUS_OFS, 32'h2, 4'hF);
      arr[v[5:0]] = 1'b1;
      look(1'b1);
      bus(1'b1, CELL_STATUS_OFS, 32'h0, 4'hF);
      look(1'b0);
   endtask : prog
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'b0;
      look(1'b0);
      repeat (16) sel_wr(8'($random(seed)));
      for (int k = 0; k < 12; k++) begin
         sel_wr(8'($random(seed)));
         look(1'b0);
      end
      for (int k = 8'h10; k <= 8'h18; k++) begin
         sel_wr(8'(k));
         look(1'b0);
      end
      prog(8'h3F);
      prog(8'h09);
      prog(8'h09);
      bus(1'b1, 4'h8, 32'hFF, 4'hF);
      bus(1'b1, CELL_SELECT_OFS, 32'hAA, 4'hE);
      look(1'b0);
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      chk(q, 32'h0);
      sel_wr(8'hC5);
      bus(1'b1, CELL_STATUS_OFS, 32'h2, 4'hF);
      arr[5] = 1'b1;
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      sel = 8'h00;
      look(1'b0);
      sel_wr(8'h05);
      look(1'b0);
      end_of_test();
   end
endmodule : personality_bit_array_access_tb_top
